// ===== verilog/txd_offload_decode.sv
// Descriptor FIFO and transmit descriptor decoder
// Summary of operation
// - VLAN mode on, insert clear: plain frame, FCS only if append bit set.
// - VLAN insert: tag type from register, tag from descriptor, FCS added.
// - Extended-format bit zero means legacy data descriptor layout.
// - Report-status writes descriptor-done after fetch; never without it.
// - Zero address or length moves no data; still writes done if asked.
// - Insert-checksum: window runs from start byte to packet end.
// - Insert-checksum dropped if start >= length or offset >= length-1.
// - Append-FCS set appends FCS at packet end; clear appends none unless VLAN is inserted.
// - VLAN, FCS, offset and checksum bits honoured only at end-of-packet.
// - Timestamp-request bit asks for a time stamp on that packet.
// - Descriptor-done, status bit 0, written only after processing.
// - Descriptor VLAN tag ignored unless insert and end-of-packet set.
// - Extended format with type 0: context, loads offload parameters.
// - IP checksum start is a byte offset within first 256 bytes.
// - IP checksum offset beyond packet length: no insertion.
// - 16-bit IP checksum end; zero means run to end of packet.
// - Transport checksum fields behave like the IP ones.
// - Segmented frames are segment size plus header; last may be short.
// - First header-length bytes form the prototype header.
// - Payload-length bytes follow header; count flags the last frame.
// - Command bits: end 0, FCS 1, sum 2, report 3, ext 5, VLAN 6, delay 7.
// - Done with delay bit reloads countdown; interrupt when it expires.
// - Legacy checksum offset is eight bits, within first 256 bytes.
`timescale 1ns/100ps

// -----------------------------------------------------------------
// Descriptor FIFO
// -----------------------------------------------------------------
module txd_fifo #(
  parameter int unsigned WIDTH = txd_pkg::DESC_W,
  parameter int unsigned DEPTH = txd_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } txd_fifo_state_s;

  txd_fifo_state_s state_reg;
  txd_fifo_state_s state_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready_o = !((state_reg.wr[AW] != state_reg.rd[AW]) &&
                        (state_reg.wr[AW-1:0] == state_reg.rd[AW-1:0]));
  assign out_valid_o = (state_reg.wr != state_reg.rd);
  assign out_data_o = mem[state_reg.rd[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.wr = state_reg.wr + 1'b1;
    end
    if (pop) begin
      state_next.rd = state_reg.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Storage needs no reset; reads are gated by the pointers
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[state_reg.wr[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// -----------------------------------------------------------------
// Decoder top
// -----------------------------------------------------------------
module txd_offload_decode #(
  parameter int unsigned FIFO_DEPTH = txd_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // Descriptor stream from the ring fetcher
  input wire logic DESC_VALID_I,
  input wire logic [127:0] DESC_I,
  output logic DESC_READY_O,
  // Configuration
  input wire logic VLAN_MODE_ENABLE_I,
  input wire logic [15:0] VLAN_ETHERTYPE_REG_I,
  input wire logic [15:0] TX_IRQ_DELAY_VALUE_I,
  // Data fetch
  output logic FETCH_REQ_O,
  output logic [63:0] FETCH_ADDR_O,
  output logic [15:0] FETCH_LEN_O,
  input wire logic FETCH_DONE_I,
  // Status write-back
  output logic WB_VALID_O,
  output logic [3:0] WB_STATUS_O,
  // Packet control at end of packet
  output logic PKT_VALID_O,
  output txd_pkg::txd_pkt_s PKT_O,
  // Offload context
  output txd_pkg::txd_ctx_s CTX_O,
  output logic [16:0] SEG_FRAME_LEN_O,
  output logic [15:0] SEG_HDR_BYTES_O,
  output logic SEG_LAST_FRAME_O,
  // Interrupt
  output logic TX_IRQ_O
);
  typedef struct packed {
    txd_pkg::txd_state_e st;
    logic [127:0] desc;
    logic fetch_req;
    logic wb_valid;
    logic pkt_valid;
    logic irq;
    logic irq_armed;
    logic [15:0] irq_cnt;
    logic mid_pkt;
    logic [15:0] pkt_len;
    logic [7:0] first_start;
    logic ts_acc;
    logic [15:0] hdr_left;
    logic [15:0] hdr_bytes;
    logic [19:0] pay_left;
    txd_pkg::txd_pkt_s pkt;
    txd_pkg::txd_ctx_s ctx;
  } txd_top_state_s;

  txd_top_state_s state_reg;
  txd_top_state_s state_next;
  logic fifo_valid;
  logic fifo_pop;
  logic [127:0] fifo_data;
  txd_pkg::txd_legacy_s leg_w;
  txd_pkg::txd_context_s ctx_w;
  txd_pkg::txd_legacy_s cur_w;

  function automatic logic [15:0] sum_end(input logic [15:0] fld,
                                          input logic [15:0] total);
    sum_end = (fld == txd_pkg::SUM_END_TO_EOP) ? total : fld;
  endfunction

  txd_fifo #(
    .WIDTH(txd_pkg::DESC_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .in_valid_i(DESC_VALID_I),
    .in_data_i(DESC_I),
    .in_ready_o(DESC_READY_O),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_pop)
  );

  assign leg_w = txd_pkg::txd_legacy_s'(fifo_data);
  assign ctx_w = txd_pkg::txd_context_s'(fifo_data);
  assign cur_w = txd_pkg::txd_legacy_s'(state_reg.desc);
  // Only one descriptor is in flight, so the FIFO stalls the ring
  assign fifo_pop = fifo_valid && (state_reg.st == txd_pkg::ST_IDLE);

  always_comb begin
    logic [15:0] hp;
    logic [15:0] total;
    logic [15:0] plen;
    logic last;
    logic vlan_on;
    hp = '0;
    total = '0;
    plen = '0;
    last = 1'b0;
    vlan_on = 1'b0;
    state_next = state_reg;
    state_next.wb_valid = 1'b0;
    state_next.pkt_valid = 1'b0;
    state_next.irq = 1'b0;
    if (state_reg.irq_armed) begin
      if (state_reg.irq_cnt == '0) begin
        state_next.irq = 1'b1;
        state_next.irq_armed = 1'b0;
      end else begin
        state_next.irq_cnt = state_reg.irq_cnt - 16'h0001;
      end
    end
    case (state_reg.st)
      txd_pkg::ST_IDLE: begin
        if (fifo_valid) begin
          state_next.desc = fifo_data;
          state_next.st = txd_pkg::ST_FINISH;
          if (!leg_w.cmd[txd_pkg::CMD_EXT]) begin
            if (!state_reg.mid_pkt) begin
              state_next.first_start = leg_w.sum_begin;
            end
            state_next.mid_pkt = 1'b1;
            state_next.ts_acc = state_reg.ts_acc |
                                leg_w.extcmd[txd_pkg::EXT_STAMP];
            if (leg_w.addr != '0 && leg_w.length != '0) begin
              state_next.st = txd_pkg::ST_FETCH;
              state_next.fetch_req = 1'b1;
            end
          end else if (ctx_w.desc_type == txd_pkg::TYPE_CONTEXT) begin
            state_next.ctx.ip_sum_start = ctx_w.ip_start;
            state_next.ctx.ip_sum_offset = ctx_w.ip_offset;
            state_next.ctx.ip_sum_end = ctx_w.ip_end;
            state_next.ctx.l4_sum_start = ctx_w.l4_start;
            state_next.ctx.l4_sum_offset = ctx_w.l4_offset;
            state_next.ctx.l4_sum_end = ctx_w.l4_end;
            state_next.ctx.max_segment_size = ctx_w.seg_size;
            state_next.ctx.header_length = ctx_w.hdr_len;
            state_next.ctx.payload_length = ctx_w.pay_len;
            state_next.ctx.segmentation_enable =
              ctx_w.tucmd[txd_pkg::TUCMD_SEG];
            state_next.ctx.is_ipv4 = ctx_w.tucmd[txd_pkg::TUCMD_IP];
            state_next.ctx.is_tcp = ctx_w.tucmd[txd_pkg::TUCMD_TCP];
            state_next.hdr_left = {8'h00, ctx_w.hdr_len};
            state_next.pay_left = ctx_w.pay_len;
          end
        end
      end
      txd_pkg::ST_FETCH: begin
        if (FETCH_DONE_I) begin
          state_next.fetch_req = 1'b0;
          state_next.st = txd_pkg::ST_FINISH;
          state_next.pkt_len = state_reg.pkt_len + cur_w.length;
          if (state_reg.ctx.segmentation_enable) begin
            // Header bytes come first, the rest counts as payload
            hp = (cur_w.length < state_reg.hdr_left) ?
                 cur_w.length : state_reg.hdr_left;
            plen = cur_w.length - hp;
            state_next.hdr_left = state_reg.hdr_left - hp;
            state_next.hdr_bytes = state_reg.hdr_bytes + hp;
            state_next.pay_left = (state_reg.pay_left > {4'h0, plen}) ?
              state_reg.pay_left - {4'h0, plen} : '0;
          end
        end
      end
      txd_pkg::ST_FINISH: begin
        state_next.st = txd_pkg::ST_IDLE;
        if (cur_w.cmd[txd_pkg::CMD_REPORT]) begin
          state_next.wb_valid = 1'b1;
          if (cur_w.cmd[txd_pkg::CMD_DELAY]) begin
            state_next.irq_armed = 1'b1;
            state_next.irq_cnt = TX_IRQ_DELAY_VALUE_I;
          end else begin
            state_next.irq = 1'b1;
            state_next.irq_armed = 1'b0;
            state_next.irq_cnt = '0;
          end
        end
        last = !cur_w.cmd[txd_pkg::CMD_EXT] && cur_w.cmd[txd_pkg::CMD_LAST];
        if (last) begin
          total = state_reg.pkt_len;
          vlan_on = VLAN_MODE_ENABLE_I && cur_w.cmd[txd_pkg::CMD_VLAN];
          state_next.pkt_valid = 1'b1;
          state_next.pkt.total_len = total;
          state_next.pkt.vlan_insert = vlan_on;
          state_next.pkt.vlan_type = vlan_on ? VLAN_ETHERTYPE_REG_I : '0;
          state_next.pkt.vlan_tag = vlan_on ? cur_w.special : '0;
          state_next.pkt.append_fcs =
            cur_w.cmd[txd_pkg::CMD_FCS] | vlan_on;
          state_next.pkt.sum_insert = cur_w.cmd[txd_pkg::CMD_SUM] &&
            ({8'h00, state_reg.first_start} < total) &&
            ({9'h000, cur_w.sum_place} + 17'h00001 < {1'b0, total});
          state_next.pkt.sum_start = state_reg.first_start;
          state_next.pkt.sum_offset = cur_w.sum_place;
          state_next.pkt.timestamp_req = state_reg.ts_acc;
          state_next.pkt.ip_insert_ok =
            ({8'h00, state_reg.ctx.ip_sum_offset} <= total);
          state_next.pkt.ip_end = sum_end(state_reg.ctx.ip_sum_end, total);
          state_next.pkt.l4_insert_ok =
            ({8'h00, state_reg.ctx.l4_sum_offset} <= total);
          state_next.pkt.l4_end = sum_end(state_reg.ctx.l4_sum_end, total);
          state_next.mid_pkt = 1'b0;
          state_next.pkt_len = '0;
          state_next.ts_acc = 1'b0;
        end
      end
      default: begin
        state_next.st = txd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign FETCH_REQ_O = state_reg.fetch_req;
  assign FETCH_ADDR_O = cur_w.addr;
  assign FETCH_LEN_O = cur_w.length;
  assign WB_VALID_O = state_reg.wb_valid;
  assign WB_STATUS_O = state_reg.wb_valid ? txd_pkg::STATUS_DONE : '0;
  assign PKT_VALID_O = state_reg.pkt_valid;
  assign PKT_O = state_reg.pkt;
  assign CTX_O = state_reg.ctx;
  assign TX_IRQ_O = state_reg.irq;
  // Segment size only matters with segmentation on
  assign SEG_FRAME_LEN_O = state_reg.ctx.segmentation_enable ?
    ({1'b0, state_reg.ctx.max_segment_size} +
     {9'h000, state_reg.ctx.header_length}) : '0;
  assign SEG_HDR_BYTES_O = state_reg.hdr_bytes;
  assign SEG_LAST_FRAME_O = state_reg.ctx.segmentation_enable &&
    (state_reg.pay_left <= {4'h0, state_reg.ctx.max_segment_size});

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence fetch_end_rs;
    FETCH_REQ_O && FETCH_DONE_I && cur_w.cmd[txd_pkg::CMD_REPORT];
  endsequence

  sequence ctx_pop;
    fifo_pop && leg_w.cmd[txd_pkg::CMD_EXT] &&
      (ctx_w.desc_type == txd_pkg::TYPE_CONTEXT);
  endsequence

  chk_fetch_nonzero: assert property ($rose(FETCH_REQ_O) |->
    (FETCH_ADDR_O != '0) && (FETCH_LEN_O != '0))
    else $error("fetch issued for empty descriptor");
  chk_done_after_fetch: assert property (fetch_end_rs |->
    ##2 WB_VALID_O)
    else $error("done write-back missing after fetch");
  chk_done_needs_rs: assert property (WB_VALID_O |->
    cur_w.cmd[txd_pkg::CMD_REPORT] && !FETCH_REQ_O)
    else $error("done written without report status");
  chk_done_bit_set: assert property (WB_VALID_O |->
    WB_STATUS_O[txd_pkg::STA_DONE])
    else $error("write-back lacks done bit");
  chk_vlan_tag_gate: assert property (PKT_VALID_O &&
    !PKT_O.vlan_insert |-> (PKT_O.vlan_tag == '0))
    else $error("vlan tag used without insert");
  chk_vlan_fcs: assert property (PKT_VALID_O && PKT_O.vlan_insert |->
    PKT_O.append_fcs)
    else $error("vlan frame without fcs");
  chk_sum_range: assert property (PKT_VALID_O && PKT_O.sum_insert |->
    ({8'h00, PKT_O.sum_start} < PKT_O.total_len) &&
    ({8'h00, PKT_O.sum_offset} + 16'h0001 < PKT_O.total_len))
    else $error("checksum inserted out of range");
  chk_ip_end_eop: assert property (PKT_VALID_O &&
    (CTX_O.ip_sum_end == '0) |-> (PKT_O.ip_end == PKT_O.total_len))
    else $error("zero end not mapped to packet end");
  chk_last_only: assert property (PKT_VALID_O |->
    cur_w.cmd[txd_pkg::CMD_LAST] && !cur_w.cmd[txd_pkg::CMD_EXT])
    else $error("packet closed without end of packet");
  chk_ctx_load: assert property (ctx_pop |=>
    (CTX_O.max_segment_size == $past(ctx_w.seg_size)) && !FETCH_REQ_O)
    else $error("context not loaded");
  chk_irq_now: assert property (WB_VALID_O &&
    !cur_w.cmd[txd_pkg::CMD_DELAY] |-> TX_IRQ_O)
    else $error("immediate interrupt missing");
endmodule

// ===== verilog/txd_pkg.sv
// Shared constants and types for the transmit descriptor decoder
package txd_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned DESC_W = 128;
  localparam int unsigned FIFO_DEPTH = 16;

  // ---------------------------------------------------------------
  // Command byte bit positions (context shares ext, report and delay; its TUCMD bits 0-2 differ)
  // ---------------------------------------------------------------
  localparam int CMD_LAST = 0;
  localparam int CMD_FCS = 1;
  localparam int CMD_SUM = 2;
  localparam int CMD_REPORT = 3;
  localparam int CMD_EXT = 5;
  localparam int CMD_VLAN = 6;
  localparam int CMD_DELAY = 7;
  localparam int TUCMD_TCP = 0;
  localparam int TUCMD_IP = 1;
  localparam int TUCMD_SEG = 2;
  localparam int EXT_STAMP = 0;
  localparam int STA_DONE = 0;

  // ---------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] TYPE_CONTEXT = 4'h0;
  localparam logic [3:0] STATUS_DONE = 4'h1;
  localparam logic [15:0] SUM_END_TO_EOP = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_FINISH = 2'b11
  } txd_state_e;

  typedef struct packed {
    logic [15:0] special;
    logic [7:0] sum_begin;
    logic [3:0] extcmd;
    logic [3:0] sta;
    logic [7:0] cmd;
    logic [7:0] sum_place;
    logic [15:0] length;
    logic [63:0] addr;
  } txd_legacy_s;

  typedef struct packed {
    logic [15:0] seg_size;
    logic [7:0] hdr_len;
    logic [3:0] rsv;
    logic [3:0] sta;
    logic [7:0] tucmd;
    logic [3:0] desc_type;
    logic [19:0] pay_len;
    logic [15:0] l4_end;
    logic [7:0] l4_offset;
    logic [7:0] l4_start;
    logic [15:0] ip_end;
    logic [7:0] ip_offset;
    logic [7:0] ip_start;
  } txd_context_s;

  typedef struct packed {
    logic [7:0] ip_sum_start;
    logic [7:0] ip_sum_offset;
    logic [15:0] ip_sum_end;
    logic [7:0] l4_sum_start;
    logic [7:0] l4_sum_offset;
    logic [15:0] l4_sum_end;
    logic [15:0] max_segment_size;
    logic [7:0] header_length;
    logic [19:0] payload_length;
    logic segmentation_enable;
    logic is_ipv4;
    logic is_tcp;
  } txd_ctx_s;

  typedef struct packed {
    logic [15:0] total_len;
    logic vlan_insert;
    logic [15:0] vlan_type;
    logic [15:0] vlan_tag;
    logic append_fcs;
    logic sum_insert;
    logic [7:0] sum_start;
    logic [7:0] sum_offset;
    logic timestamp_req;
    logic ip_insert_ok;
    logic [15:0] ip_end;
    logic l4_insert_ok;
    logic [15:0] l4_end;
  } txd_pkt_s;

endpackage

// ===== tb/txd_fetch_model.sv
// Fetch responder standing for host memory behind the data fetch port
`timescale 1ns/100ps

module txd_fetch_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Fetch handshake
  input wire logic req_i,
  input wire logic [7:0] delay_i,
  output logic done_o
);
  logic [7:0] cnt_reg;

  // One done pulse per request; compare with >= so a lowered delay
  // mid-wait never wraps the counter
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= 8'h00;
      done_o <= 1'b0;
    end else if (done_o || !req_i) begin
      cnt_reg <= 8'h00;
      done_o <= 1'b0;
    end else if (cnt_reg >= delay_i) begin
      done_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule

// ===== tb/test_txd_offload_decode.sv
// Self-checking bench for the transmit descriptor decoder
`timescale 1ns/100ps

module test_txd_offload_decode;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic CLK_I, RST_B_I, DESC_VALID_I, DESC_READY_O, VLAN_MODE_ENABLE_I;
  logic [127:0] DESC_I;
  logic [15:0] VLAN_ETHERTYPE_REG_I, TX_IRQ_DELAY_VALUE_I, FETCH_LEN_O;
  logic FETCH_REQ_O, FETCH_DONE_I, WB_VALID_O, PKT_VALID_O;
  logic [63:0] FETCH_ADDR_O, fa;
  logic [3:0] WB_STATUS_O;
  txd_pkg::txd_pkt_s PKT_O, pkt;
  txd_pkg::txd_ctx_s CTX_O;
  logic [16:0] SEG_FRAME_LEN_O;
  logic [15:0] SEG_HDR_BYTES_O, fl;
  logic SEG_LAST_FRAME_O, TX_IRQ_O, req_q;
  logic [7:0] fetch_delay;
  int mismatches, cmp_count, cyc, wb_n, pkt_n, irq_n, fetch_n;
  int wb_cyc, irq_cyc, w0, p0, i0, f0;
  logic [7:0] tcs [4] = '{8'd19, 8'd20, 8'd3, 8'd0};
  logic [7:0] tco [4] = '{8'd18, 8'd5, 8'd19, 8'd18};
  logic tex [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  localparam logic [7:0] c_end = 8'h01;
  localparam logic [7:0] c_fcs = 8'h02;
  localparam logic [7:0] c_sum = 8'h04;
  localparam logic [7:0] c_rep = 8'h08;
  localparam logic [7:0] c_vlan = 8'h40;
  localparam logic [7:0] c_dly = 8'h80;

  txd_offload_decode #(.FIFO_DEPTH(16)) txd_offload_decode_inst (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .DESC_VALID_I(DESC_VALID_I),
    .DESC_I(DESC_I), .DESC_READY_O(DESC_READY_O),
    .VLAN_MODE_ENABLE_I(VLAN_MODE_ENABLE_I),
    .VLAN_ETHERTYPE_REG_I(VLAN_ETHERTYPE_REG_I),
    .TX_IRQ_DELAY_VALUE_I(TX_IRQ_DELAY_VALUE_I),
    .FETCH_REQ_O(FETCH_REQ_O), .FETCH_ADDR_O(FETCH_ADDR_O),
    .FETCH_LEN_O(FETCH_LEN_O), .FETCH_DONE_I(FETCH_DONE_I),
    .WB_VALID_O(WB_VALID_O), .WB_STATUS_O(WB_STATUS_O),
    .PKT_VALID_O(PKT_VALID_O), .PKT_O(PKT_O), .CTX_O(CTX_O),
    .SEG_FRAME_LEN_O(SEG_FRAME_LEN_O), .SEG_HDR_BYTES_O(SEG_HDR_BYTES_O),
    .SEG_LAST_FRAME_O(SEG_LAST_FRAME_O), .TX_IRQ_O(TX_IRQ_O)
  );

  txd_fetch_model txd_fetch_model_inst (
    .clk_i(CLK_I), .rst_b_i(RST_B_I), .req_i(FETCH_REQ_O),
    .delay_i(fetch_delay), .done_o(FETCH_DONE_I)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [127:0] leg(input logic [63:0] a,
    input logic [15:0] l, input logic [7:0] cm, input logic [7:0] cs,
    input logic [7:0] co, input logic [15:0] sp, input logic [3:0] ext);
    return txd_pkg::txd_legacy_s'{sp, cs, ext, 4'h0, cm, co, l, a};
  endfunction

  function automatic logic [127:0] ctx(input logic [15:0] ms,
    input logic [7:0] hl, input logic [7:0] tc, input logic [19:0] pl,
    input logic [15:0] le, input logic [7:0] lo, input logic [7:0] io);
    return txd_pkg::txd_context_s'{ms, hl, 4'h0, 4'h0, tc,
      txd_pkg::TYPE_CONTEXT, pl, le, lo, 8'h00, 16'h0000, io, 8'h00};
  endfunction

  task automatic chk(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic snap();
    w0 = wb_n;
    p0 = pkt_n;
    i0 = irq_n;
    f0 = fetch_n;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask

  // Valid stays up after a take; quiet() is what withdraws it
  task automatic send(input logic [127:0] d);
    int n;
    n = 0;
    DESC_I = d;
    DESC_VALID_I = 1'b1;
    do begin
      @(negedge CLK_I);
      n++;
    end while (DESC_READY_O !== 1'b1 && n < 1000);
    @(posedge CLK_I);
    #1;
  endtask

  task automatic quiet();
    int n;
    int q;
    n = 0;
    q = 0;
    DESC_VALID_I = 1'b0;
    while (q < 6 && n < 1000) begin
      @(negedge CLK_I);
      n++;
      q = (FETCH_REQ_O === 1'b0) ? q + 1 : 0;
    end
    if (q < 6) chk(1'b0, "fetch never ended");
    idle(1);
  endtask

  // ---------------------------------------------------------------
  // Monitor, sampled at the falling edge where outputs are settled
  // ---------------------------------------------------------------
  always @(negedge CLK_I) begin
    cyc++;
    chk(WB_STATUS_O === ((WB_VALID_O === 1'b1) ? 4'h1 : 4'h0), "status");
    if (WB_VALID_O === 1'b1) begin
      wb_n++;
      wb_cyc = cyc;
    end
    if (PKT_VALID_O === 1'b1) begin
      pkt_n++;
      pkt = PKT_O;
    end
    if (TX_IRQ_O === 1'b1) begin
      irq_n++;
      irq_cyc = cyc;
    end
    if (FETCH_REQ_O === 1'b1 && req_q !== 1'b1) begin
      fetch_n++;
      fa = FETCH_ADDR_O;
      fl = FETCH_LEN_O;
    end
    req_q = FETCH_REQ_O;
  end

  initial begin
    #200000;
    chk(1'b0, "watchdog expired");
    final_report();
  end

  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    RST_B_I = 1'b0;
    DESC_VALID_I = 1'b0;
    DESC_I = '0;
    VLAN_MODE_ENABLE_I = 1'b1;
    VLAN_ETHERTYPE_REG_I = 16'h9a5c;
    TX_IRQ_DELAY_VALUE_I = 16'd20;
    fetch_delay = 8'd3;
    idle(3);
    RST_B_I = 1'b1;
    chk(DESC_READY_O === 1'b1 && FETCH_REQ_O === 1'b0, "reset state");
    snap();
    send(leg(64'h1000, 16'd100, c_end | c_fcs | c_sum | c_rep | c_vlan, 8'd10, 8'd50, 16'h2bcd, 4'h1));
    quiet();
    chk(fa === 64'h1000 && fl === 16'd100, "fetch address");
    chk(wb_n == w0 + 1 && pkt_n == p0 + 1, "one write-back");
    chk(pkt === txd_pkg::txd_pkt_s'{16'd100, 1'b1, 16'h9a5c, 16'h2bcd, 1'b1,
      1'b1, 8'd10, 8'd50, 1'b1, 1'b1, 16'd100, 1'b1, 16'd100}, "vlan");
    snap();
    send(leg(64'h2000, 16'd30, c_fcs | c_sum | c_vlan, 8'd4, 8'd99, 16'hffff, 4'h0));
    send(leg(64'h3000, 16'd40, c_end | c_fcs | c_sum, 8'd77, 8'd20, 16'h1234, 4'h0));
    quiet();
    chk(wb_n == w0 && fetch_n == f0 + 2 && pkt_n == p0 + 1, "no status");
    chk(pkt === txd_pkg::txd_pkt_s'{16'd70, 1'b0, 16'h0, 16'h0, 1'b1, 1'b1,
      8'd4, 8'd20, 1'b0, 1'b1, 16'd70, 1'b1, 16'd70}, "two parts");
    send(leg(64'h4000, 16'd64, c_end, 8'd0, 8'd0, 16'h5555, 4'h0));
    quiet();
    chk(pkt === txd_pkg::txd_pkt_s'{16'd64, 1'b0, 16'h0, 16'h0, 1'b0, 1'b0,
      8'd0, 8'd0, 1'b0, 1'b1, 16'd64, 1'b1, 16'd64}, "plain frame");
    fetch_delay = 8'd0;
    for (int k = 0; k < 4; k++) begin
      send(leg(64'h5000, 16'd20, c_end | c_fcs | c_sum, tcs[k], tco[k], 16'h0, 4'h0));
      quiet();
      chk(pkt.sum_insert === tex[k], "checksum window");
    end
    snap();
    send(leg(64'h0, 16'd16, c_end | c_rep, 8'd0, 8'd0, 16'h0, 4'h0));
    send(leg(64'h40, 16'd0, c_end | c_rep, 8'd0, 8'd0, 16'h0, 4'h0));
    quiet();
    chk(fetch_n == f0 && wb_n == w0 + 2, "empty descriptors");
    snap();
    send(leg(64'h0, 16'd8, c_end | c_rep | c_dly, 8'd0, 8'd0, 16'h0, 4'h0));
    quiet();
    idle(30);
    chk(irq_n == i0 + 1 && irq_cyc - wb_cyc == 21, "delayed irq");
    snap();
    send(leg(64'h0, 16'd8, c_end | c_rep | c_dly, 8'd0, 8'd0, 16'h0, 4'h0));
    send(leg(64'h0, 16'd8, c_end | c_rep, 8'd0, 8'd0, 16'h0, 4'h0));
    quiet();
    idle(30);
    chk(irq_n == i0 + 1 && irq_cyc == wb_cyc, "timer cleared");
    fetch_delay = 8'd200;
    snap();
    for (int k = 0; k < 17; k++) begin
      send(leg(64'h100, 16'd1, c_end | c_fcs | c_rep, 8'd0, 8'd0, 16'h0, 4'h0));
    end
    @(negedge CLK_I);
    chk(DESC_READY_O === 1'b0, "fifo full");
    idle(1);
    fetch_delay = 8'd0;
    quiet();
    chk(wb_n == w0 + 17 && fetch_n == f0 + 17, "drained");
    snap();
    send(ctx(16'd100, 8'd54, 8'h2f, 20'd50, 16'h0010, 8'd10, 8'd30));
    quiet();
    chk(fetch_n == f0 && wb_n == w0 + 1, "context done");
    chk(CTX_O.max_segment_size === 16'd100 && CTX_O.header_length === 8'd54
      && CTX_O.payload_length === 20'd50 && CTX_O.ip_sum_offset === 8'd30,
      "context fields");
    chk(SEG_FRAME_LEN_O === 17'd154 && SEG_LAST_FRAME_O === 1'b1, "seg");
    send(leg(64'h6000, 16'd20, c_end | c_fcs, 8'd0, 8'd0, 16'h0, 4'h0));
    quiet();
    chk(pkt.ip_insert_ok === 1'b0 && pkt.ip_end === 16'd20
      && pkt.l4_insert_ok === 1'b1 && pkt.l4_end === 16'h0010, "win");
    chk(SEG_HDR_BYTES_O === 16'd20, "prototype header");
    send(ctx(16'd100, 8'd54, 8'h28, 20'd50, 16'h0, 8'd0, 8'd0));
    quiet();
    chk(SEG_FRAME_LEN_O === 17'h0, "segmentation off");
    final_report();
  end
endmodule
